//--- aar_top.v
// Alarm aggregation router with AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "aar_regs.vh"

module aar_top (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Alarm sources
   input wire [15:0] alarm_src,
   // Alarm outputs
   output reg relay_a,
   output reg relay_b,
   output reg led_mod,
   output reg led_dem,
   output reg led_sum,
   output wire oc_mod_o,
   output wire oc_mod_oe,
   output wire oc_dem_o,
   output wire oc_dem_oe,
   output reg sw_req,
   output wire irq,
   // AXI4-Lite write address
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   reg [15:0] alarm_r;
   reg [15:0] rela_r;
   reg [15:0] relb_r;
   reg [1:0] ctrl_r;
   reg [2:0] intst_r;
   reg [2:0] intmsk_r;
   reg aw_hold_r;
   reg w_hold_r;
   reg [4:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg [2:0] prev_r;
   wire [15:0] hit_a;
   wire [15:0] hit_b;
   wire any_a;
   wire any_b;
   reg sw_nxt;
   reg [2:0] ev_now;
   wire [2:0] ev_rise;
   wire do_wr;
   wire [4:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire do_rd;
   reg [31:0] rd_nxt;
   reg [1:0] rd_resp_nxt;
   reg [2:0] w1c;

   // Merge byte lanes of a write onto a 16-bit register
   // Upper lanes hold no bits, so their strobes are ignored
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = old;
         if (strb[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   // Known register decode
   function mapped;
      input [4:0] a;
      begin
         mapped = (a == `AAR_OFS_RELA) || (a == `AAR_OFS_RELB) ||
                  (a == `AAR_OFS_CTRL) || (a == `AAR_OFS_STAT) ||
                  (a == `AAR_OFS_INTST) || (a == `AAR_OFS_INTMSK);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Alarm path

   // Register inputs so every output works from one sampled alarm word
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         alarm_r <= 16'h0000;
      end else begin
         alarm_r <= alarm_src;
      end
   end

   // Route registers feed the masks directly; a write reaches the pins one edge later
   aar_route u_route (
      .alarm_in(alarm_r),
      .sel_a(rela_r),
      .sel_b(relb_r),
      .hit_a(hit_a),
      .hit_b(hit_b)
   );

   assign any_a = |hit_a;
   assign any_b = |hit_b;

   // Mode 0 ignores routing, so an ignored source can still request a switch
   always @* begin
      case (ctrl_r)
         `AAR_SW_ANY: sw_nxt = |alarm_r;
         `AAR_SW_A: sw_nxt = any_a;
         `AAR_SW_B: sw_nxt = any_b;
         `AAR_SW_AB: sw_nxt = any_a & any_b;
         default: sw_nxt = 1'b0;
      endcase
   end

   // All outputs registered: one cycle after the sampled change
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         relay_a <= 1'b0;
         relay_b <= 1'b0;
         led_mod <= 1'b0;
         led_dem <= 1'b0;
         led_sum <= 1'b0;
         sw_req <= 1'b0;
      end else begin
         relay_a <= any_a;
         relay_b <= any_b;
         // led_mod and led_dem follow the source groups; led_sum follows the routing
         led_mod <= |(alarm_r & `AAR_SRC_MOD);
         led_dem <= |(alarm_r & `AAR_SRC_DEM);
         led_sum <= any_a | any_b;
         sw_req <= sw_nxt;
      end
   end

   // Open collector: pull low while alarmed, release otherwise
   assign oc_mod_o = 1'b0;
   assign oc_mod_oe = led_mod;
   assign oc_dem_o = 1'b0;
   assign oc_dem_oe = led_dem;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts on rising relay and switch-request states

   // Edge memory resets to the idle level, so reset alone raises no event
   always @* begin
      ev_now = 3'h0;
      ev_now[`AAR_ST_RELA] = relay_a;
      ev_now[`AAR_ST_RELB] = relay_b;
      ev_now[`AAR_ST_SWREQ] = sw_req;
   end
   assign ev_rise = ev_now & ~prev_r;
   assign irq = |(intst_r & intmsk_r);

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side; address and data taken in either order

   // Readies drop while a response waits: one write in flight at a time
   assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
   assign wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
   assign wr_data = w_hold_r ? wdata_r : s_axi_wdata;
   assign wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
   assign do_wr = (aw_hold_r | (s_axi_awvalid & s_axi_awready)) &
                  (w_hold_r | (s_axi_wvalid & s_axi_wready));

   always @* begin
      w1c = 3'h0;
      // Clear bits ride on lane 0 only
      if (do_wr && wr_addr == `AAR_OFS_INTST && wr_strb[0]) begin
         w1c = wr_data[2:0];
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 5'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AAR_RESP_OKAY;
         rela_r <= `AAR_RELA_RST;
         relb_r <= `AAR_RELB_RST;
         ctrl_r <= `AAR_CTRL_RST;
         intmsk_r <= 3'h0;
         intst_r <= 3'h0;
         prev_r <= 3'h0;
      end else begin
         prev_r <= ev_now;
         // Set wins over a simultaneous write-one clear
         intst_r <= (intst_r & ~w1c) | ev_rise;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wr_addr) ? `AAR_RESP_OKAY : `AAR_RESP_SLVERR;
            case (wr_addr)
               `AAR_OFS_RELA: rela_r <= merge16(rela_r, wr_data, wr_strb);
               `AAR_OFS_RELB: relb_r <= merge16(relb_r, wr_data, wr_strb);
               `AAR_OFS_CTRL: begin
                  if (wr_strb[0]) begin
                     ctrl_r <= wr_data[`AAR_CTRL_MODE_HI:`AAR_CTRL_MODE_LO];
                  end
               end
               `AAR_OFS_INTMSK: begin
                  if (wr_strb[0]) begin
                     intmsk_r <= wr_data[2:0];
                  end
               end
               default: ;
            endcase
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_hold_r <= 1'b1;
               awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_hold_r <= 1'b1;
               wdata_r <= s_axi_wdata;
               wstrb_r <= s_axi_wstrb;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side

   assign s_axi_arready = ~s_axi_rvalid;
   assign do_rd = s_axi_arvalid & s_axi_arready;

   always @* begin
      rd_nxt = 32'h00000000;
      rd_resp_nxt = `AAR_RESP_OKAY;
      case (s_axi_araddr)
         `AAR_OFS_RELA: rd_nxt = {16'h0000, rela_r};
         `AAR_OFS_RELB: rd_nxt = {16'h0000, relb_r};
         `AAR_OFS_CTRL: rd_nxt = {30'h00000000, ctrl_r};
         `AAR_OFS_STAT: rd_nxt = {alarm_r, 13'h0000, ev_now};
         `AAR_OFS_INTST: rd_nxt = {29'h00000000, intst_r};
         `AAR_OFS_INTMSK: rd_nxt = {29'h00000000, intmsk_r};
         default: rd_resp_nxt = `AAR_RESP_SLVERR;
      endcase
   end

   // Data is captured at acceptance and holds until the handshake
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AAR_RESP_OKAY;
      end else begin
         if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_resp_nxt;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

//--- aar_regs.vh
// Register map, field layout and reset values of the alarm router
`ifndef AAR_REGS_VH
`define AAR_REGS_VH

`define AAR_NSRC 16
`define AAR_ADDR_W 5

// Byte offsets
`define AAR_OFS_RELA 5'h00
`define AAR_OFS_RELB 5'h04
`define AAR_OFS_CTRL 5'h08
`define AAR_OFS_STAT 5'h0c
`define AAR_OFS_INTST 5'h10
`define AAR_OFS_INTMSK 5'h14

// Source index groups
`define AAR_SRC_UNIT 16'h0007
`define AAR_SRC_MOD 16'h00f8
`define AAR_SRC_DEM 16'h1f00
`define AAR_SRC_IFC 16'hf000

// Reset routing: modulator sources on A, demodulator sources on B
`define AAR_RELA_RST 16'h00f8
`define AAR_RELB_RST 16'h1f00

// Control fields
`define AAR_CTRL_MODE_LO 0
`define AAR_CTRL_MODE_HI 1
`define AAR_CTRL_RST 2'h0

// Switch request modes
`define AAR_SW_ANY 2'h0
`define AAR_SW_A 2'h1
`define AAR_SW_B 2'h2
`define AAR_SW_AB 2'h3

// Status / interrupt bit positions
`define AAR_ST_RELA 0
`define AAR_ST_RELB 1
`define AAR_ST_SWREQ 2
`define AAR_INT_W 3

`define AAR_RESP_OKAY 2'h0
`define AAR_RESP_SLVERR 2'h2

`endif

//--- aar_route.v
// Per-source routing of alarm inputs onto relay A and relay B
`timescale 1ns/1ps
`include "aar_regs.vh"

module aar_route (
   // Alarm inputs and routing masks
   input wire [15:0] alarm_in,
   input wire [15:0] sel_a,
   input wire [15:0] sel_b,
   // Routed results
   output wire [15:0] hit_a,
   output wire [15:0] hit_b
);

   genvar i;
   generate
      for (i = 0; i < `AAR_NSRC; i = i + 1) begin : g_src
         // Neither bit set: source ignored
         assign hit_a[i] = alarm_in[i] & sel_a[i];
         assign hit_b[i] = alarm_in[i] & sel_b[i];
      end
   endgenerate

endmodule

//--- aar_checker_asserts.sv
// Port-level assertions and covers for the alarm router
`timescale 1ns/1ps
`include "aar_regs.vh"
module aar_checker (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Alarm side
   input wire [15:0] alarm_src,
   input wire relay_a,
   input wire relay_b,
   input wire led_mod,
   input wire led_dem,
   input wire led_sum,
   input wire oc_mod_o,
   input wire oc_mod_oe,
   input wire oc_dem_o,
   input wire oc_dem_oe,
   input wire sw_req,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Past samples from inside reset are not trusted
   reg [1:0] up_r;
   always @(posedge mclk or posedge rst) begin
      if (rst)
         up_r <= 2'h0;
      else if (up_r != 2'h3)
         up_r <= up_r + 2'h1;
   end
   wire warm = (up_r == 2'h3);
   wire src_mod = |(alarm_src & `AAR_SRC_MOD);
   a_sum_or: assert property (led_sum == (relay_a | relay_b)) else $error("summary wrong");
   a_oc_mod: assert property (oc_mod_oe == led_mod && !oc_mod_o)
      else $error("mod pin wrong");
   a_oc_dem: assert property (oc_dem_oe == led_dem && !oc_dem_o)
      else $error("dem pin wrong");
   a_led_mod: assert property (warm |-> led_mod == $past(src_mod, 2))
      else $error("mod led wrong");
   a_led_dem: assert property (warm && |(alarm_src & `AAR_SRC_DEM) |=> ##1 led_dem)
      else $error("dem led late");
   a_relay_cause: assert property (warm && (relay_a || relay_b) |-> |$past(alarm_src, 2))
      else $error("relay without alarm");
   a_sw_cause: assert property (warm && sw_req |-> |$past(alarm_src, 2))
      else $error("switch without alarm");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid && !s_axi_awready) else $error("write not answered");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1])
      else $error("read not answered");
   c_both: cover property (relay_a && relay_b);
   c_sw: cover property ($rose(sw_req));
   c_rd: cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind aar_top aar_checker u_chk (.mclk, .rst, .alarm_src, .relay_a, .relay_b, .led_mod,
   .led_dem, .led_sum, .oc_mod_o, .oc_mod_oe, .oc_dem_o, .oc_dem_oe, .sw_req, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid);

//--- aar_far_end.sv
// Far-side model: pulled-up open-collector alarm pins
`timescale 1ns/1ps
module aar_far_end (
   // Pin drivers of the router
   input wire oc_mod_o,
   input wire oc_mod_oe,
   input wire oc_dem_o,
   input wire oc_dem_oe,
   // Wire levels, low means alarm
   output wire mod_pin_n,
   output wire dem_pin_n
);
   // Released pin floats up through the switch's pull-up
   assign mod_pin_n = oc_mod_oe ? oc_mod_o : 1'b1;
   assign dem_pin_n = oc_dem_oe ? oc_dem_o : 1'b1;
endmodule

//--- alarm_aggregation_router_bench.sv
// Self-checking bench for the alarm router
`timescale 1ns/1ps
`include "aar_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module alarm_aggregation_router_bench;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [15:0] alarm_src = 16'h0;
   reg [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire relay_a, relay_b, led_mod, led_dem, led_sum, sw_req, irq, mod_pin_n, dem_pin_n;
   wire oc_mod_o, oc_mod_oe, oc_dem_o, oc_dem_oe;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer failures = 0, n_checks = 0, cyc = 0, i;
   reg [31:0] rd_d;
   reg [1:0] rsp;
   reg [15:0] ra, rb;
   aar_top DUT (.mclk, .rst, .alarm_src, .relay_a, .relay_b, .led_mod, .led_dem, .led_sum,
      .oc_mod_o, .oc_mod_oe, .oc_dem_o, .oc_dem_oe, .sw_req, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   aar_far_end u_far (.oc_mod_o, .oc_mod_oe, .oc_dem_o, .oc_dem_oe, .mod_pin_n, .dem_pin_n);
   ////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task wr(input [4:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
         rsp = s_axi_bresp;
         #1;
      end
   endtask
   task rd(input [4:0] a);
      begin
         @(posedge mclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
         rsp = s_axi_rresp;
         rd_d = s_axi_rdata;
      end
   endtask
   function [5:0] expect_out(input [15:0] s, input [1:0] m);
      reg a, b;
      begin
         a = |(s & ra);
         b = |(s & rb);
         expect_out = {(m == 2'h0) ? |s : (m == 2'h1) ? a : (m == 2'h2) ? b : a & b,
            |(s & `AAR_SRC_DEM), |(s & `AAR_SRC_MOD), a | b, b, a};
      end
   endfunction
   // Routing first, then alarms, so the two-edge latency is measured exactly
   task apply(input [15:0] s, input [1:0] m);
      reg [5:0] ex;
      begin
         wr(`AAR_OFS_RELA, {16'h0, ra});
         wr(`AAR_OFS_RELB, {16'h0, rb});
         wr(`AAR_OFS_CTRL, {30'h0, m});
         `CHK(rsp, `AAR_RESP_OKAY)
         @(posedge mclk);
         alarm_src <= s;
         repeat (2) @(posedge mclk);
         #1;
         ex = expect_out(s, m);
         `CHK({sw_req, led_dem, led_mod, led_sum, relay_b, relay_a}, ex)
         `CHK({dem_pin_n, mod_pin_n}, ~ex[4:3])
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         failures = failures + 1;
         tally_and_finish;
      end
   end
   initial begin
      i = $urandom(32'hf928a839);
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(`AAR_OFS_RELA);
      `CHK(rd_d, {16'h0, `AAR_RELA_RST})
      rd(`AAR_OFS_RELB);
      `CHK(rd_d, {16'h0, `AAR_RELB_RST})
      rd(5'h18);
      `CHK(rsp, `AAR_RESP_SLVERR)
      wr(5'h1c, 32'h5);
      `CHK(rsp, `AAR_RESP_SLVERR)
      s_axi_wstrb <= 4'h1;
      wr(`AAR_OFS_RELA, 32'h0000ff07);
      s_axi_wstrb <= 4'hf;
      rd(`AAR_OFS_RELA);
      `CHK(rd_d, 32'h00000007)
      $display("test reset done");
      ra = `AAR_RELA_RST;
      rb = `AAR_RELB_RST;
      for (i = 0; i < 16; i++)
         apply(16'h1 << i, 2'h0);
      $display("test sources done");
      for (i = 0; i < 40; i++) begin
         {ra, rb} = (i == 0) ? 32'h0 : $urandom;
         apply((i < 4) ? 16'hffff : 16'($urandom), i[1:0]);
      end
      $display("test routing done");
      ra = `AAR_RELA_RST;
      rb = `AAR_RELB_RST;
      apply(16'h0, 2'h0);
      wr(`AAR_OFS_INTST, 32'h7);
      wr(`AAR_OFS_INTMSK, 32'h1);
      `CHK(irq, 1'b0)
      apply(16'h0008, 2'h0);
      @(posedge mclk);
      #1;
      `CHK(irq, 1'b1)
      rd(`AAR_OFS_STAT);
      `CHK(rd_d, 32'h00080005)
      wr(`AAR_OFS_INTMSK, 32'h0);
      `CHK(irq, 1'b0)
      wr(`AAR_OFS_INTMSK, 32'h1);
      `CHK(irq, 1'b1)
      wr(`AAR_OFS_INTST, 32'h1);
      `CHK(irq, 1'b0)
      $display("test interrupt done");
      tally_and_finish;
   end
endmodule
